// ### rtl/fdos_defines.vh
// Constants of the fractional divider and output stage block.
// Included by the top module and the output path module; definitions only.
`ifndef FDOS_DEFINES_VH
`define FDOS_DEFINES_VH

// ----------------------------------------------------------------
// Register map: channel stride and word offsets inside a channel
// ----------------------------------------------------------------
`define FDOS_CH_STRIDE 32'h00000040
`define FDOS_OFF_INT 4'h0
`define FDOS_OFF_FRAC_LO 4'h1
`define FDOS_OFF_FRAC_HI 4'h2
`define FDOS_OFF_FINE_ADJ 4'h3
`define FDOS_OFF_FINE_CTRL 4'h4
`define FDOS_OFF_P0_DIV 4'h5
`define FDOS_OFF_P0_HIGH 4'h6
`define FDOS_OFF_P0_CTRL 4'h7
`define FDOS_OFF_P1_DIV 4'h8
`define FDOS_OFF_P1_HIGH 4'h9
`define FDOS_OFF_P1_CTRL 4'ha

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FDOS_INT_W 8
`define FDOS_FRAC_W 43
`define FDOS_FRAC_HI_W 11
`define FDOS_RATE_LSB 0
`define FDOS_RATE_MSB 1
`define FDOS_BUSY_BIT 8
`define FDOS_CTRL_EN_BIT 0
`define FDOS_CTRL_DIFF_BIT 1
`define FDOS_CTRL_INV_BIT 2
`define FDOS_CTRL_LVL_BIT 8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FDOS_RST_INT 8'h0e
`define FDOS_RST_DIV 32'h00000002
`define FDOS_RST_HIGH 32'h00000000
`define FDOS_RST_CTRL 3'h0
`define FDOS_RST_RATE 2'h0

// ----------------------------------------------------------------
// Fine adjust rates: synthesizer cycles added or removed per period
// ----------------------------------------------------------------
`define FDOS_RATE_SLOW 2'h0
`define FDOS_RATE_MED 2'h1
`define FDOS_RATE_FAST 2'h2
`define FDOS_STEP_SLOW 8'h01
`define FDOS_STEP_MED 8'h02
`define FDOS_STEP_FAST 8'h04
// Picoseconds represented by one synthesizer cycle
`define FDOS_SYNTH_PS 32'sd74

`endif

// ### rtl/fdos_path.v
// One output path: 32-bit integer divider with high-width shaping.
// Assumes fod_tick is a one-cycle pulse per divider clock, on ref_clk.
`timescale 1ns/1ns
`include "fdos_defines.vh"

module fdos_path (
  input wire ref_clk,
  input wire arst_n,
  input wire ce,
  input wire fod_tick,
  input wire [31:0] div_val,
  input wire [31:0] high_val,
  input wire enable,
  input wire invert,
  input wire diff_mode,
  output reg true_pin,
  output reg comp_pin,
  output wire level
);

  // ----------------------------------------------------------------
  // Divider count
  // ----------------------------------------------------------------
  reg [31:0] cnt_q;
  reg [31:0] cnt_d;
  reg out_q;
  reg out_d;
  reg [31:0] hi_len;
  reg [31:0] div_eff;

  // High length: programmed width, else half the divide count
  always @* begin
    div_eff = (div_val == 32'h00000000) ? 32'h00000001 : div_val;
    hi_len = (high_val != 32'h00000000) ? high_val : {1'b0, div_eff[31:1]};
  end

  // Next count and level; a shrunk divide value wraps at once
  always @* begin
    cnt_d = cnt_q;
    out_d = out_q;
    if (!enable) begin
      cnt_d = 32'h00000000;
      out_d = 1'b0;
    end else if (fod_tick) begin
      if (cnt_q >= div_eff - 32'h00000001)
        cnt_d = 32'h00000000;
      else
        cnt_d = cnt_q + 32'h00000001;
      if (div_eff == 32'h00000001)
        out_d = ~out_q;
      else
        out_d = (cnt_d < hi_len);
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 32'h00000000;
      out_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Complement pin: inverted in differential mode, else optional invert
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      true_pin <= 1'b0;
      comp_pin <= 1'b0;
    end else if (ce) begin
      true_pin <= out_d;
      comp_pin <= (diff_mode | invert) ? ~out_d : out_d;
    end
  end

  assign level = out_q;

endmodule // fdos_path

// ### rtl/fdos_top.v
// Four steerable fractional dividers, each feeding a dual output stage.
// AHB-Lite register slave on ref_clk; one ref_clk cycle stands for one
// synthesizer clock cycle, so the divider runs as a tick generator.
`timescale 1ns/1ns
`include "fdos_defines.vh"

module fdos_top (
  input wire ref_clk,
  input wire arst_n,
  input wire ce,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  output wire [3:0] fod_fb_tick,
  output wire [7:0] true_output_pin,
  output wire [7:0] complement_output_pin
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Rate codes 2 and 3 both give the fast step, so every code is decoded
  // and the code written is the code read back.
  // Synthesizer cycles moved per period for a rate code
  function [7:0] fdos_step;
    input [1:0] rate;
    begin
      case (rate)
        `FDOS_RATE_SLOW: fdos_step = `FDOS_STEP_SLOW;
        `FDOS_RATE_MED: fdos_step = `FDOS_STEP_MED;
        default: fdos_step = `FDOS_STEP_FAST;
      endcase
    end
  endfunction

  // Channel bits 7:6 are decoded apart; bits 1:0 are ignored because only
  // whole aligned words are transferred.
  // Word offset inside a channel, or 4'hf for an unmapped address
  function [3:0] fdos_word;
    input [31:0] addr;
    begin
      if (addr[31:8] != 24'h000000 || addr[5:2] > `FDOS_OFF_P1_CTRL)
        fdos_word = 4'hf;
      else
        fdos_word = addr[5:2];
    end
  endfunction

  // ----------------------------------------------------------------
  // Configuration registers, one set per channel
  // ----------------------------------------------------------------
  reg [`FDOS_INT_W-1:0] int_q [0:3];
  reg [`FDOS_FRAC_W-1:0] frac_q [0:3];
  reg [1:0] rate_q [0:3];
  reg [31:0] div_q [0:7];
  reg [31:0] high_q [0:7];
  reg [2:0] ctrl_q [0:7];
  wire signed [31:0] off_q [0:3];
  wire [7:0] lvl;

  // ----------------------------------------------------------------
  // AHB-Lite slave: writes zero-wait, reads one wait state
  // ----------------------------------------------------------------
  reg wr_pend_q;
  reg rd_pend_q;
  reg rd_wait_q;
  reg [31:0] addr_q;
  wire take;
  wire [3:0] wr_word;
  wire [1:0] wr_ch;
  wire [3:0] wr_fine;
  integer i;

  // Writes need no wait state: the data phase edge writes the register
  // straight from hwdata. Reads pay one wait state so that hrdata comes
  // from a flop rather than straight from the wide read mux.
  assign take = hsel & htrans[1] & hready;
  assign hresp = 1'b0;
  // Read data phase holds one cycle so hrdata can come from a flop
  assign hreadyout = ce & ~(rd_pend_q & rd_wait_q);
  assign wr_word = fdos_word(addr_q);
  assign wr_ch = addr_q[7:6];
  assign wr_fine = (wr_pend_q && wr_word == `FDOS_OFF_FINE_ADJ) ?
                   (4'h1 << wr_ch) : 4'h0;

  // Address phase capture and read wait tracking
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      rd_wait_q <= 1'b0;
      addr_q <= 32'h00000000;
    end else if (ce) begin
      if (hreadyout) begin
        wr_pend_q <= take & hwrite;
        rd_pend_q <= take & ~hwrite;
        rd_wait_q <= take & ~hwrite;
        if (take)
          addr_q <= haddr;
      end else begin
        rd_wait_q <= 1'b0;
      end
    end
  end

  // Register writes land in the data phase
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < 4; i = i + 1) begin
        int_q[i] <= `FDOS_RST_INT;
        frac_q[i] <= {`FDOS_FRAC_W{1'b0}};
        rate_q[i] <= `FDOS_RST_RATE;
      end
      for (i = 0; i < 8; i = i + 1) begin
        div_q[i] <= `FDOS_RST_DIV;
        high_q[i] <= `FDOS_RST_HIGH;
        ctrl_q[i] <= `FDOS_RST_CTRL;
      end
    end else if (ce && wr_pend_q) begin
      case (wr_word)
        `FDOS_OFF_INT: int_q[wr_ch] <= hwdata[`FDOS_INT_W-1:0];
        `FDOS_OFF_FRAC_LO: frac_q[wr_ch][31:0] <= hwdata;
        `FDOS_OFF_FRAC_HI: frac_q[wr_ch][42:32] <= hwdata[`FDOS_FRAC_HI_W-1:0];
        `FDOS_OFF_FINE_CTRL: rate_q[wr_ch] <= hwdata[`FDOS_RATE_MSB:`FDOS_RATE_LSB];
        `FDOS_OFF_P0_DIV: div_q[{wr_ch, 1'b0}] <= hwdata;
        `FDOS_OFF_P0_HIGH: high_q[{wr_ch, 1'b0}] <= hwdata;
        `FDOS_OFF_P0_CTRL: ctrl_q[{wr_ch, 1'b0}] <= hwdata[2:0];
        `FDOS_OFF_P1_DIV: div_q[{wr_ch, 1'b1}] <= hwdata;
        `FDOS_OFF_P1_HIGH: high_q[{wr_ch, 1'b1}] <= hwdata;
        `FDOS_OFF_P1_CTRL: ctrl_q[{wr_ch, 1'b1}] <= hwdata[2:0];
        default: ;
      endcase
    end
  end

  // Read mux into the data register; unmapped reads give zero
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h00000000;
    case (fdos_word(addr_q))
      `FDOS_OFF_INT: rd_d = {24'h000000, int_q[wr_ch]};
      `FDOS_OFF_FRAC_LO: rd_d = frac_q[wr_ch][31:0];
      `FDOS_OFF_FRAC_HI: rd_d = {21'h000000, frac_q[wr_ch][42:32]};
      `FDOS_OFF_FINE_ADJ: rd_d = off_q[wr_ch];
      `FDOS_OFF_FINE_CTRL: rd_d = {23'h000000, (off_q[wr_ch] != 32'sd0),
                                   6'h00, rate_q[wr_ch]};
      `FDOS_OFF_P0_DIV: rd_d = div_q[{wr_ch, 1'b0}];
      `FDOS_OFF_P0_HIGH: rd_d = high_q[{wr_ch, 1'b0}];
      `FDOS_OFF_P0_CTRL: rd_d = {23'h000000, lvl[{wr_ch, 1'b0}], 5'h00,
                                 ctrl_q[{wr_ch, 1'b0}]};
      `FDOS_OFF_P1_DIV: rd_d = div_q[{wr_ch, 1'b1}];
      `FDOS_OFF_P1_HIGH: rd_d = high_q[{wr_ch, 1'b1}];
      `FDOS_OFF_P1_CTRL: rd_d = {23'h000000, lvl[{wr_ch, 1'b1}], 5'h00,
                                 ctrl_q[{wr_ch, 1'b1}]};
      default: rd_d = 32'h00000000;
    endcase
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      hrdata <= 32'h00000000;
    else if (ce && rd_pend_q && rd_wait_q)
      hrdata <= rd_d;
  end

  // ----------------------------------------------------------------
  // Steerable fractional dividers, one per channel
  // ----------------------------------------------------------------
  // Each divider is a down counter reloaded with INT plus the carry of a
  // 43-bit fraction accumulator, so the mean period is INT + FRAC/2^43.
  // Fine adjust moves whole synthesizer cycles per period at the chosen
  // rate; a residue below one step is dropped, so the phase left over
  // after an adjustment is under one step of the selected rate.
  // The tick is registered so the feedback output and the output paths
  // see the same edge.
  genvar c;
  generate
    for (c = 0; c < 4; c = c + 1) begin : g_fod
      reg [7:0] cnt_q;
      reg [`FDOS_FRAC_W-1:0] acc_q;
      reg signed [31:0] adj_q;
      reg tick_q;
      reg [7:0] cnt_d;
      reg [`FDOS_FRAC_W-1:0] acc_d;
      reg signed [31:0] adj_d;
      reg [`FDOS_FRAC_W:0] sum;
      reg [7:0] len;
      reg [7:0] step;
      reg signed [31:0] step_ps;
      wire period_end;

      // A count of one is the last cycle of a period
      assign period_end = (cnt_q <= 8'h01);

      // Next period length with fraction carry and phase steering
      always @* begin
        step = fdos_step(rate_q[c]);
        step_ps = $signed({24'h000000, step}) * `FDOS_SYNTH_PS;
        sum = {1'b0, acc_q} + {1'b0, frac_q[c]};
        len = int_q[c] + {7'h00, sum[`FDOS_FRAC_W]};
        acc_d = acc_q;
        adj_d = adj_q;
        cnt_d = cnt_q - 8'h01;
        if (period_end) begin
          acc_d = sum[`FDOS_FRAC_W-1:0];
          if (adj_q <= -step_ps) begin
            len = len - step;
            adj_d = adj_q + step_ps;
          end else if (adj_q >= step_ps) begin
            len = len + step;
            adj_d = adj_q - step_ps;
          end else begin
            // Residue below one step cannot be placed; drop it
            adj_d = 32'sd0;
          end
          // A zero length would stall the counter; run at one cycle instead
          cnt_d = (len == 8'h00) ? 8'h01 : len;
        end
        if (wr_fine[c])
          adj_d = adj_d + $signed(hwdata);
      end

      always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          cnt_q <= 8'h01;
          acc_q <= {`FDOS_FRAC_W{1'b0}};
          adj_q <= 32'sd0;
          tick_q <= 1'b0;
        end else if (ce) begin
          cnt_q <= cnt_d;
          acc_q <= acc_d;
          adj_q <= adj_d;
          tick_q <= period_end;
        end
      end

      assign off_q[c] = adj_q;
      assign fod_fb_tick[c] = tick_q;

      // ----------------------------------------------------------------
      // Dual output stage: two identical paths on the same divider
      // ----------------------------------------------------------------
      // Both paths share the tick but keep their own divide, width and pin
      // control, so one channel can give a clock and a frame pulse at once.
      genvar p;
      for (p = 0; p < 2; p = p + 1) begin : g_path
        fdos_path u_path (
          .ref_clk(ref_clk),
          .arst_n(arst_n),
          .ce(ce),
          .fod_tick(tick_q),
          .div_val(div_q[2*c+p]),
          .high_val(high_q[2*c+p]),
          .enable(ctrl_q[2*c+p][`FDOS_CTRL_EN_BIT]),
          .invert(ctrl_q[2*c+p][`FDOS_CTRL_INV_BIT]),
          .diff_mode(ctrl_q[2*c+p][`FDOS_CTRL_DIFF_BIT]),
          .true_pin(true_output_pin[2*c+p]),
          .comp_pin(complement_output_pin[2*c+p]),
          .level(lvl[2*c+p])
        );
      end
    end
  endgenerate

endmodule // fdos_top

// ### tb/fdos_rx.sv
// Clock receiver model: measures period and high width of one pin.
// Assumes the pin changes only just after rising ref_clk edges.
`timescale 1ns/1ns
module fdos_rx (
  input wire logic ref_clk,
  input wire logic pin,
  output logic [31:0] hi_len,
  output logic [31:0] per_len
);
  logic p_q = 1'b0;
  logic [31:0] cnt_q = 32'h0;
  logic [31:0] hc_q = 32'h0;
  // Rise to rise gives period, rise to fall gives high width
  always @(posedge ref_clk) begin
    p_q <= pin;
    cnt_q <= (pin && !p_q) ? 32'h1 : cnt_q + 32'h1;
    hc_q <= pin ? hc_q + 32'h1 : 32'h0;
    if (pin && !p_q) per_len <= cnt_q;
    if (!pin && p_q) hi_len <= hc_q;
  end
endmodule // fdos_rx

// ### tb/fdos_top_sva.sv
// Concurrent checks on the ports of the divider and output stage top.
// Assumes software keeps the documented ratio limits; bound in by the bench.
`timescale 1ns/1ns
module fdos_top_sva (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [3:0] fod_fb_tick,
  input wire logic [7:0] true_output_pin,
  input wire logic [7:0] complement_output_pin
);
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  logic rd_q;
  logic [5:0] since_wr_q;
  logic live_q;
  logic ce_q;
  wire take = hsel & htrans[1] & hready & ce;
  // Frozen with ce, since the design freezes too
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_q <= 1'b0;
      since_wr_q <= 6'h3f;
    end else if (ce) begin
      rd_q <= take & ~hwrite;
      since_wr_q <= (take & hwrite) ? 6'h0 : since_wr_q + {5'h0, since_wr_q != 6'h3f};
    end
  end
  // Past values that straddle a reset are not compared; only the tick checks also skip a ce stall
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      live_q <= 1'b0;
      ce_q <= 1'b0;
    end else begin
      live_q <= 1'b1;
      ce_q <= ce;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n || !live_q);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
  a_ce_stall: assert property (!ce |-> !hreadyout) else $error("ready while ce low");
  a_wr_nowait: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
  a_rd_onewait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  a_rdata_hold: assert property (!$stable(hrdata) |-> $past(rd_q)) else $error("rdata moved");
  a_tick_gap: assert property (disable iff (!arst_n || !live_q || !ce || !ce_q)
    fod_fb_tick[3] |=> !fod_fb_tick[3] [*8]) else $error("tick too soon");
  a_tick_bound: assert property (disable iff (!arst_n || !live_q || !ce || !ce_q)
    fod_fb_tick[0] |-> ##[9:40] fod_fb_tick[0]) else $error("tick too late");
  a_comp_mode: assert property (
    !$stable(true_output_pin ^ complement_output_pin) |-> since_wr_q <= 6'd40)
    else $error("pin pair relation moved");
  a_tick_pulse: assert property (disable iff (!arst_n || !live_q || !ce || !ce_q)
    fod_fb_tick[0] |=> !fod_fb_tick[0]) else $error("tick not a pulse");
  c_read: cover property (take && !hwrite);
  c_tick: cover property (fod_fb_tick[0]);
  c_inv: cover property (true_output_pin[3] && !complement_output_pin[3]);
endmodule // fdos_top_sva

// ### tb/testbench.sv
// Self-checking bench for the divider and output stage top.
// Acts as the only AHB-Lite master; receivers watch every true pin.
`timescale 1ns/1ns
`include "fdos_defines.vh"
module testbench;
  logic ref_clk = 1'b0, arst_n = 1'b0, ce = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  wire hreadyout, hresp;
  wire [31:0] hrdata;
  wire [3:0] tick;
  wire [7:0] tp, cp;
  wire [31:0] hi_len [8], per_len [8];
  int mismatches = 0, total_checks = 0, cyc = 0, c0, ch, pn, w;
  // Ch, path, INT, DIV, HIGH, CTRL, expected high and period in cycles
  // legal ratios and widths in every row
  int rows [5][8] = '{'{0, 0, 14, 2, 0, 1, 14, 28}, '{1, 1, 14, 5, 2, 3, 28, 70},
    '{1, 0, 14, 5, 2, 3, 28, 70}, '{2, 0, 20, 4, 0, 5, 40, 80}, '{3, 1, 27, 3, 1, 1, 27, 81}};
  // Rate, two adjust writes in ps, expected change of 20 periods
  int fr [5][4] = '{'{0, 740, 0, 10}, '{1, -740, 0, -10}, '{2, -740, 0, -8},
    '{3, 296, 0, 4}, '{0, 370, 370, 10}};
  always #25 ref_clk = ~ref_clk;
  fdos_top dut_u(.ref_clk, .arst_n, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .fod_fb_tick(tick),
    .true_output_pin(tp), .complement_output_pin(cp));
  for (genvar g = 0; g < 8; g++) begin : g_rx
    fdos_rx rx_u(.ref_clk, .pin(tp[g]), .hi_len(hi_len[g]), .per_len(per_len[g]));
  end
  // Cycle count doubles as the hang limit
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Ready is sampled mid-cycle, where it has settled
  task wait_rdy;
    logic r;
    do begin
      @(negedge ref_clk) r = hreadyout;
      @(posedge ref_clk);
    end while (r !== 1'b1);
  endtask
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask
  function automatic logic [31:0] ra(int c, int wd);
    return c * `FDOS_CH_STRIDE + wd * 4;
  endfunction
  task tk;
    do @(negedge ref_clk); while (tick[0] !== 1'b1);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    ce <= 1'b1;
    @(posedge ref_clk);
    bus(0, ra(3, `FDOS_OFF_INT), 0);
    chk(rd, {24'h0, `FDOS_RST_INT});
    bus(0, ra(3, `FDOS_OFF_P1_DIV), 0);
    chk(rd, `FDOS_RST_DIV);
    foreach (rows[i]) begin
      ch = rows[i][0];
      pn = 2 * ch + rows[i][1];
      w = 5 + 3 * rows[i][1];
      bus(1, ra(ch, `FDOS_OFF_INT), rows[i][2]);
      bus(1, ra(ch, w), rows[i][3]);
      bus(1, ra(ch, w + 1), rows[i][4]);
      bus(1, ra(ch, w + 2), rows[i][5]);
      repeat (3 * rows[i][7] + 40) @(posedge ref_clk);
      chk(hi_len[pn], rows[i][6]);
      chk(per_len[pn], rows[i][7]);
      repeat (rows[i][7]) begin
        @(negedge ref_clk);
        chk(cp[pn] ^ tp[pn], (rows[i][5] & 6) != 0);
      end
      @(posedge ref_clk);
    end
    chk({tp[1], cp[1]}, 0);
    // Half fraction: periods alternate 14 and 15
    bus(1, ra(0, `FDOS_OFF_FRAC_HI), 32'h400);
    tk;
    tk;
    c0 = cyc;
    repeat (16) tk;
    chk(cyc - c0, 232);
    @(posedge ref_clk);
    bus(1, ra(0, `FDOS_OFF_FRAC_HI), 0);
    // open loop only: no tracking loop around this divider
    foreach (fr[i]) begin
      bus(1, ra(0, `FDOS_OFF_FINE_CTRL), fr[i][0]);
      tk;
      c0 = cyc;
      fork
        repeat (20) tk;
        begin
          @(posedge ref_clk);
          bus(1, ra(0, `FDOS_OFF_FINE_ADJ), fr[i][1]);
          bus(1, ra(0, `FDOS_OFF_FINE_ADJ), fr[i][2]);
        end
      join
      chk(cyc - c0, 280 + fr[i][3]);
      @(posedge ref_clk);
      bus(0, ra(0, `FDOS_OFF_FINE_ADJ), 0);
      chk(rd, 0);
      bus(0, ra(0, `FDOS_OFF_FINE_CTRL), 0);
      chk(rd & 32'h103, fr[i][0]);
    end
    // Unmapped places read zero and ignore writes
    bus(1, 32'h100, 32'hffffffff);
    bus(0, 32'h100, 0);
    chk(rd, 0);
    bus(0, ra(0, 11), 0);
    chk(rd, 0);
    // Low fraction word: tiny offset keeps channel 1 inside the legal ratio
    bus(1, ra(1, `FDOS_OFF_FRAC_LO), 32'h00000100);
    bus(0, ra(1, `FDOS_OFF_FRAC_LO), 0);
    chk(rd, 32'h00000100);
    ce <= 1'b0;
    repeat (4) begin
      @(negedge ref_clk);
      chk(hreadyout, 0);
    end
    @(posedge ref_clk) ce <= 1'b1;
    @(posedge ref_clk) arst_n <= 1'b0;
    @(negedge ref_clk);
    chk({tp, cp}, 0);
    @(posedge ref_clk) arst_n <= 1'b1;
    @(posedge ref_clk);
    bus(0, ra(3, `FDOS_OFF_INT), 0);
    chk(rd, {24'h0, `FDOS_RST_INT});
    report_and_stop();
  end
endmodule // testbench

bind fdos_top fdos_top_sva chk_u(.ref_clk, .arst_n, .ce, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .hrdata, .fod_fb_tick, .true_output_pin, .complement_output_pin);
